// ---- cpsi_defines.vh ----
// constants for the core program-flow, stack and indirect-addressing block
// assumes inclusion by bare name from the design file
`ifndef CPSI_DEFINES_VH
`define CPSI_DEFINES_VH
// register word indices; not all are multiples of four
`define CPSI_IDX_RESET_CAUSE 12'h08E
`define CPSI_IDX_OSC_TRIM 12'h090
`define CPSI_IDX_PC_LOW 12'h002
`define CPSI_IDX_PC_HIGH_LATCH 12'h00A
`define CPSI_IDX_POINTER 12'h004
`define CPSI_IDX_BANK_EXT 12'h003
`define CPSI_IDX_CORE_STATUS 12'h0A0
// apb byte addresses: one aligned word per register, four times the index
`define CPSI_OFF_RESET_CAUSE (`CPSI_IDX_RESET_CAUSE << 2)
`define CPSI_OFF_OSC_TRIM (`CPSI_IDX_OSC_TRIM << 2)
`define CPSI_OFF_PC_LOW (`CPSI_IDX_PC_LOW << 2)
`define CPSI_OFF_PC_HIGH_LATCH (`CPSI_IDX_PC_HIGH_LATCH << 2)
`define CPSI_OFF_POINTER (`CPSI_IDX_POINTER << 2)
`define CPSI_OFF_BANK_EXT (`CPSI_IDX_BANK_EXT << 2)
`define CPSI_OFF_CORE_STATUS (`CPSI_IDX_CORE_STATUS << 2)
// field positions
`define CPSI_BIT_BROWNOUT 0
`define CPSI_BIT_POWERON 1
`define CPSI_TRIM_LSB 2
`define CPSI_TRIM_MSB 7
`define CPSI_BIT_BANK_EXT 7
// reset values
`define CPSI_RST_TRIM 6'h20
`define CPSI_RST_PC 13'h0000
// indirect operand address in the data space
`define CPSI_INDIRECT_ADDR 8'h00
`endif

// ---- cpsi_core.v ----
// core program counter, circular return stack, indirect address former
// and the reset-cause and oscillator-trim registers on an apb slave.
// assumes instruction decode drives the one-cycle strobes on sys_clk and
// that detector inputs come from another domain.
//
// What this block does
// [RQ1] power-on event clears reset-cause bit 1; reads 1 otherwise; software rewrites 1
// [RQ2] brown-out event clears reset-cause bit 0; software sets it back to 1
// [RQ3] reset-cause bits 7..2 read zero and ignore writes
// [RQ4] trim register holds 6-bit field in bits 7..2; bits 1..0 read zero
// [RQ5] program counter is 13 bits; low byte register, upper bits from latch
// [RQ6] every reset clears the whole program counter
// [RQ7] writing the low byte loads upper bits from latch bits 4..0
// [RQ8] call or jump takes top counter bits from latch bits 4..3
// [RQ9] computed jumps across 256-byte blocks need software care with the latch
// [RQ10] eight-entry 13-bit stack, pointer neither readable nor writable
// [RQ11] call or interrupt vectoring pushes the current program counter plus one
// [RQ12] return, literal return and interrupt exit pop into the counter
// [RQ13] pushes and pops never touch the high-byte latch
// [RQ14] stack wraps circularly; ninth push overwrites the first entry
// [RQ15] no overflow or underflow indication exists
// [RQ16] indirect operand has no storage; access goes to pointed location
// [RQ17] indirect self-pointing reads 00h and writes do nothing
// [RQ18] indirect address is bank-extension bit above the 8-bit pointer
// [RQ19] call or jump takes counter bits 10..0 from the operand
// [RQ20] pops mirror pushes circularly, returning stale entries silently
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`include "cpsi_defines.vh"

module cpsi_core #(
  parameter STACK_DEPTH = 8,
  parameter PC_WIDTH = 13
) (
  // clock and reset
  input wire sys_clk,
  input wire nrst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // reset detectors, asynchronous levels
  input wire poweron_event,
  input wire brownout_event,
  // instruction strobes from decode, same clock
  input wire step_pc,
  input wire call_instr,
  input wire jump_instr,
  input wire interrupt_vector,
  input wire [12:0] vector_addr,
  input wire [10:0] target_addr,
  input wire return_instr,
  input wire literal_return_instr,
  input wire interrupt_exit_instr,
  // indirect data access from decode
  input wire indirect_read,
  input wire indirect_write,
  input wire [7:0] indirect_wdata,
  input wire [7:0] data_rdata,
  // outputs to core
  output reg [12:0] program_counter,
  output reg [8:0] indirect_addr,
  output reg indirect_data_we,
  output reg [7:0] indirect_data_wdata,
  output reg [7:0] indirect_rdata,
  output reg [5:0] trim_field
);

  ////////////////////////////////////////////////////////////////////////
  // synchronisers and edge detect for the reset detectors
  reg [1:0] por_sync_reg;
  reg [1:0] bod_sync_reg;
  reg por_seen_reg;
  reg bod_seen_reg;
  wire por_rise;
  wire bod_rise;

  // power-on detector: two flops, then a delayed copy for the edge
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      por_sync_reg <= 2'h0;
      por_seen_reg <= 1'b0;
    end else begin
      por_sync_reg <= {por_sync_reg[0], poweron_event};
      por_seen_reg <= por_sync_reg[1];
    end
  end

  // brown-out detector; idle low, so no false edge right after reset
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bod_sync_reg <= 2'h0;
      bod_seen_reg <= 1'b0;
    end else begin
      bod_sync_reg <= {bod_sync_reg[0], brownout_event};
      bod_seen_reg <= bod_sync_reg[1];
    end
  end

  assign por_rise = por_sync_reg[1] & ~por_seen_reg;
  assign bod_rise = bod_sync_reg[1] & ~bod_seen_reg;

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  wire apb_access;
  wire apb_wr;
  wire hit_cause;
  wire hit_trim;
  wire hit_pcl;
  wire hit_latch;
  wire hit_ptr;
  wire hit_bank;
  wire hit_status;
  wire addr_ok;
  wire wr_cause;
  wire wr_trim;
  wire wr_pcl;
  wire wr_latch;
  wire wr_ptr;
  wire wr_bank;

  // exact match of the held bus address against one register's address
  function cpsi_addr_hit;
    input [11:0] addr;
    input [11:0] off;
    begin
      cpsi_addr_hit = (addr == off);
    end
  endfunction

  // access phase before the answer; pready rises at the next edge
  assign apb_access = psel & penable & ~pready;
  // writes land only at the edge where the master samples pready high
  assign apb_wr = psel & penable & pready & pwrite;
  assign hit_cause = cpsi_addr_hit(paddr, `CPSI_OFF_RESET_CAUSE);
  assign hit_trim = cpsi_addr_hit(paddr, `CPSI_OFF_OSC_TRIM);
  assign hit_pcl = cpsi_addr_hit(paddr, `CPSI_OFF_PC_LOW);
  assign hit_latch = cpsi_addr_hit(paddr, `CPSI_OFF_PC_HIGH_LATCH);
  assign hit_ptr = cpsi_addr_hit(paddr, `CPSI_OFF_POINTER);
  assign hit_bank = cpsi_addr_hit(paddr, `CPSI_OFF_BANK_EXT);
  assign hit_status = cpsi_addr_hit(paddr, `CPSI_OFF_CORE_STATUS);
  assign addr_ok = hit_cause | hit_trim | hit_pcl | hit_latch | hit_ptr | hit_bank
                   | hit_status;

  // one write strobe per writable register; status word is read only
  assign wr_cause = apb_wr & hit_cause;
  assign wr_trim = apb_wr & hit_trim;
  assign wr_pcl = apb_wr & hit_pcl;
  assign wr_latch = apb_wr & hit_latch;
  assign wr_ptr = apb_wr & hit_ptr;
  assign wr_bank = apb_wr & hit_bank;

  ////////////////////////////////////////////////////////////////////////
  // reset-cause flags and trim
  reg poweron_flag_reg;
  reg brownout_flag_reg;
  reg [4:0] pc_high_latch_reg;
  reg [7:0] pointer_reg;
  reg bank_ext_reg;

  // power-on flag; reset counts as power-on, event clear beats a write
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      poweron_flag_reg <= 1'b0; // RQ1
    end else if (por_rise) begin
      poweron_flag_reg <= 1'b0; // RQ1
    end else if (wr_cause) begin
      poweron_flag_reg <= pwdata[`CPSI_BIT_POWERON]; // RQ1
    end
  end

  // brown-out flag; same priority, so an event is never lost to a write
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      brownout_flag_reg <= 1'b1;
    end else if (bod_rise) begin
      brownout_flag_reg <= 1'b0; // RQ2
    end else if (wr_cause) begin
      brownout_flag_reg <= pwdata[`CPSI_BIT_BROWNOUT]; // RQ2
    end
  end

  // trim field; reset leaves the oscillator at its centre setting
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      trim_field <= `CPSI_RST_TRIM;
    end else if (wr_trim) begin
      trim_field <= pwdata[`CPSI_TRIM_MSB:`CPSI_TRIM_LSB]; // RQ4
    end
  end

  // high-byte latch; only the bus writes it, never stack traffic
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pc_high_latch_reg <= 5'h00;
    end else if (wr_latch) begin
      pc_high_latch_reg <= pwdata[4:0]; // RQ13
    end
  end

  // pointer register for indirect access
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pointer_reg <= 8'h00;
    end else if (wr_ptr) begin
      pointer_reg <= pwdata[7:0];
    end
  end

  // bank-extension bit, kept at bit 7 of its word
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bank_ext_reg <= 1'b0;
    end else if (wr_bank) begin
      bank_ext_reg <= pwdata[`CPSI_BIT_BANK_EXT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // return stack, circular with no overflow status
  reg [PC_WIDTH-1:0] stack_mem [0:STACK_DEPTH-1];
  // wrap relies on natural overflow of three bits, so depth must stay eight
  localparam PTR_W = 3;
  reg [PTR_W-1:0] stack_ptr_reg;
  wire do_push;
  wire do_pop;
  wire [PTR_W-1:0] pop_idx;
  integer i;

  assign do_push = call_instr | interrupt_vector; // RQ11
  assign do_pop = return_instr | literal_return_instr | interrupt_exit_instr; // RQ12
  assign pop_idx = stack_ptr_reg - 3'h1;

  // pointer wraps modulo depth; nothing flags over or underflow
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stack_ptr_reg <= 3'h0;
    end else if (do_push) begin
      stack_ptr_reg <= stack_ptr_reg + 3'h1; // RQ14 RQ15
    end else if (do_pop) begin
      stack_ptr_reg <= pop_idx; // RQ20
    end
  end

  // storage; a ninth push simply overwrites the oldest slot
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < STACK_DEPTH; i = i + 1) begin
        stack_mem[i] <= `CPSI_RST_PC;
      end
    end else if (do_push) begin
      stack_mem[stack_ptr_reg] <= program_counter + 13'h0001; // RQ10 RQ14
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // program counter; the latch is never written by stack traffic
  reg [12:0] pc_next;

  always @* begin
    pc_next = program_counter;
    if (do_push && interrupt_vector) begin
      pc_next = vector_addr;
    end else if (call_instr || jump_instr) begin
      pc_next = {pc_high_latch_reg[4:3], target_addr}; // RQ8 RQ19
    end else if (do_pop) begin
      pc_next = stack_mem[pop_idx]; // RQ12 RQ13
    end else if (wr_pcl) begin
      pc_next = {pc_high_latch_reg, pwdata[7:0]}; // RQ7 RQ5
    end else if (step_pc) begin
      pc_next = program_counter + 13'h0001;
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      program_counter <= `CPSI_RST_PC; // RQ6
    end else begin
      program_counter <= pc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // indirect addressing path
  wire self_point;

  assign self_point = ({bank_ext_reg, pointer_reg} == {1'b0, `CPSI_INDIRECT_ADDR});

  // address follows pointer and bank one cycle late; outputs are flops
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      indirect_addr <= 9'h000;
    end else begin
      indirect_addr <= {bank_ext_reg, pointer_reg}; // RQ18
    end
  end

  // write strobe dropped when the pointer selects the operand itself
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      indirect_data_we <= 1'b0;
      indirect_data_wdata <= 8'h00;
    end else begin
      indirect_data_we <= indirect_write & ~self_point; // RQ16 RQ17
      indirect_data_wdata <= indirect_wdata; // RQ16
    end
  end

  // read data captured on a read strobe only, held otherwise
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      indirect_rdata <= 8'h00;
    end else if (indirect_read) begin
      indirect_rdata <= self_point ? 8'h00 : data_rdata; // RQ16 RQ17
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb read mux and answer
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    if (hit_cause) begin
      rd_mux = {30'h00000000, poweron_flag_reg, brownout_flag_reg}; // RQ3
    end else if (hit_trim) begin
      rd_mux = {24'h000000, trim_field, 2'h0}; // RQ4
    end else if (hit_pcl) begin
      rd_mux = {24'h000000, program_counter[7:0]}; // RQ5
    end else if (hit_latch) begin
      rd_mux = {27'h0000000, pc_high_latch_reg};
    end else if (hit_ptr) begin
      rd_mux = {24'h000000, pointer_reg};
    end else if (hit_bank) begin
      rd_mux = {24'h000000, bank_ext_reg, 7'h00};
    end else if (hit_status) begin
      rd_mux = {19'h00000, program_counter}; // RQ10
    end
  end

  // answer one cycle into the access phase; unmapped gives pslverr
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_access;
      pslverr <= apb_access & ~addr_ok;
    end
  end

  // read data taken with pready rising, so it stands when sampled
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
    end else if (apb_access && !pwrite) begin
      prdata <= rd_mux;
    end
  end

endmodule

// ---- cpsi_core_asserts.sv ----
// checker for the core program-flow block, bound to cpsi_core
// assumes the pointer stays put around indirect reads
`timescale 1ns/100ps
module cpsi_core_asserts (
  // clock and reset
  input wire sys_clk,
  input wire nrst,
  // apb handshake
  input wire psel, penable, pready, pslverr,
  // instruction strobes
  input wire step_pc, call_instr, jump_instr, interrupt_vector,
  input wire return_instr, literal_return_instr, interrupt_exit_instr,
  input wire [12:0] vector_addr,
  input wire [10:0] target_addr,
  // indirect path
  input wire indirect_read, indirect_write, indirect_data_we,
  input wire [8:0] indirect_addr,
  input wire [7:0] indirect_rdata, data_rdata,
  // counter
  input wire [12:0] program_counter
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////
  // a_vector_load and a_call_target also catch a wrong strobe priority
  a_reset_pc_zero: assert property ($rose(nrst) |-> program_counter == 13'h0000)
    else $error("pc not zero after reset");
  a_apb_wait_one: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_call_target: assert property (
    (call_instr || jump_instr) && !interrupt_vector |=> program_counter[10:0] == $past(target_addr))
    else $error("call target wrong");
  a_vector_load: assert property (
    interrupt_vector |=> program_counter == $past(vector_addr)) else $error("vector wrong");
  a_step_inc: assert property (step_pc && !(call_instr || jump_instr || interrupt_vector ||
    return_instr || literal_return_instr || interrupt_exit_instr || psel)
    |=> program_counter == $past(program_counter) + 13'h1) else $error("step wrong");
  a_write_cause: assert property (indirect_data_we |-> $past(indirect_write))
    else $error("stray write");
  a_self_read_zero: assert property (
    indirect_read && indirect_addr == 9'h000 |=> indirect_rdata == 8'h00) else $error("self read");
  a_read_through: assert property (
    indirect_read && indirect_addr != 9'h000 |=> indirect_rdata == $past(data_rdata))
    else $error("indirect read wrong");
endmodule
bind cpsi_core cpsi_core_asserts i_cpsi_core_asserts (.*);

// ---- cpsi_core_tb.sv ----
// bench for cpsi_core: apb tasks, strobe pulses and a stack model
// assumes the apb slave answers by itself and strobes are one cycle
`timescale 1ns/100ps
module cpsi_core_tb;
  reg sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, er;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rv;
  reg poweron_event = 0, brownout_event = 0, indirect_read = 0, indirect_write = 0;
  reg [6:0] s = 0;
  reg [12:0] vector_addr = 0, pc_x, stk [0:7];
  reg [10:0] target_addr = 0;
  reg [7:0] indirect_wdata = 0, data_rdata = 0;
  reg [2:0] sp = 0;
  wire step_pc = s[0], call_instr = s[1], jump_instr = s[2], interrupt_vector = s[3];
  wire return_instr = s[4], literal_return_instr = s[5], interrupt_exit_instr = s[6];
  wire [31:0] prdata;
  wire pready, pslverr, indirect_data_we;
  wire [12:0] program_counter;
  wire [8:0] indirect_addr;
  wire [7:0] indirect_data_wdata, indirect_rdata;
  wire [5:0] trim_field;
  integer miscompares = 0, checks = 0, cyc = 0, i;
  cpsi_core i_cpsi_core (.*);
  ////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      miscompares = miscompares + 1;
      summarize;
    end
  end
  ////////////////////////////////////////////////////////////////
  task chk(input [31:0] g, input [31:0] e); begin
    checks = checks + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  end endtask
  // request held until pready is seen high at an edge
  task apb(input [11:0] a, input w, input [31:0] d); begin
    @(posedge sys_clk);
    {psel, paddr, pwrite, pwdata} <= {1'b1, a, w, d};
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    @(negedge sys_clk);
  end endtask
  task rd(input [11:0] a, input [31:0] e); begin
    apb(a, 0, 0);
    chk(rv, e);
  end endtask
  task tr(input [7:0] d); begin
    apb(12'h240, 1, d);
    rd(12'h240, d & 8'hFC);
    chk(trim_field, d[7:2]);
  end endtask
  // one-cycle strobe; result seen at the falling edge after
  task st(input [6:0] m, input [10:0] t); begin
    @(posedge sys_clk);
    {s, target_addr, vector_addr} <= {m, t, 2'b01, t};
    @(posedge sys_clk);
    s <= 0;
    @(negedge sys_clk);
  end endtask
  task ind(input w, input [7:0] d); begin
    @(posedge sys_clk);
    {indirect_write, indirect_read, indirect_wdata, data_rdata} <= {w, !w, d, d};
    @(posedge sys_clk);
    {indirect_write, indirect_read} <= 2'b00;
    @(negedge sys_clk);
  end endtask
  task summarize; begin
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1;
    chk(program_counter, 0);
    rd(12'h238, 32'h01);
    rd(12'h100, 0);
    chk(er, 1);
    apb(12'h238, 1, 32'hFF);
    rd(12'h238, 32'h03);
    @(posedge sys_clk);
    brownout_event <= 1;
    repeat (4) @(posedge sys_clk);
    brownout_event <= 0;
    rd(12'h238, 32'h02);
    @(posedge sys_clk);
    poweron_event <= 1;
    repeat (4) @(posedge sys_clk);
    poweron_event <= 0;
    rd(12'h238, 32'h00);
    $display("test flags done");
    rd(12'h240, 32'h80);
    tr(8'hFF);
    tr(8'h00);
    tr(8'h81);
    $display("test trim done");
    apb(12'h028, 1, 32'h15);
    apb(12'h008, 1, 32'h34);
    chk(program_counter, 13'h1534);
    rd(12'h280, 32'h1534);
    st(7'h01, 0);
    chk(program_counter, 13'h1535);
    st(7'h04, 11'h0AA);
    chk(program_counter, 13'h10AA);
    pc_x = 13'h10AA;
    // nine pushes, the ninth lands on the first slot
    for (i = 0; i < 9; i = i + 1) begin
      st(i == 4 ? 7'h08 : 7'h02, 11'h100 + i);
      stk[sp] = pc_x + 13'h1;
      sp = sp + 3'h1;
      pc_x = {i == 4 ? 2'b01 : 2'b10, 11'h100 + i[10:0]};
      chk(program_counter, pc_x);
    end
    for (i = 0; i < 9; i = i + 1) begin
      st(7'h10 << (i % 3), 0);
      sp = sp - 3'h1;
      chk(program_counter, stk[sp]);
    end
    rd(12'h028, 32'h15);
    $display("test stack done");
    apb(12'h010, 1, 32'h40);
    apb(12'h00C, 1, 32'h80);
    @(negedge sys_clk);
    chk(indirect_addr, 9'h140);
    ind(1, 8'h5A);
    chk({indirect_data_we, indirect_data_wdata}, 9'h15A);
    ind(0, 8'h77);
    chk(indirect_rdata, 8'h77);
    apb(12'h010, 1, 0);
    apb(12'h00C, 1, 0);
    ind(0, 8'h77);
    chk(indirect_rdata, 8'h00);
    ind(1, 8'h5A);
    chk(indirect_data_we, 0);
    $display("test indirect done");
    @(posedge sys_clk);
    nrst <= 0;
    @(posedge sys_clk);
    nrst <= 1;
    @(negedge sys_clk);
    chk(program_counter, 0);
    rd(12'h238, 32'h01);
    $display("test reset done");
    summarize;
  end
endmodule
